// file: design/vff_bank.sv
// fault filter, temperature calibration and alert mask bank
// Function
// - fault after N+1 consecutive violations, N=cfg[3:0]
// - reported temperature is raw times stored gain
// - gain write outside 0.1..10 rejected, kept
// - offset added; writes outside +-100 rejected
// - masked fault classes never assert alert pin
// - mask bytes map to status bytes; byte5 unused
// - alert mask clears to zero at reset
`timescale 1ns/1ps
module vff_bank (
    // clock and reset
    input  wire logic              mclk,
    input  wire logic              sys_rst,
    // command port from the transport layer
    input  wire vff_pkg::vff_cmd_s cmd_in,
    output vff_pkg::vff_rsp_s      rsp_out,
    // output voltage comparators, one sample per strobe
    input  wire logic              vout_sample,
    input  wire logic              vout_ov_viol,
    input  wire logic              vout_uv_viol,
    output logic                   vout_fault,
    // temperature path, raw value in degrees with 8 fraction bits
    input  wire logic              temp_valid,
    input  wire logic signed [15:0] temp_raw,
    output logic                   temp_out_valid,
    output logic signed [31:0]     temp_cal,
    // fault status bytes and alert pin
    input  wire logic [55:0]       fault_status,
    output logic                   alert_output_pin
);
    import vff_pkg::*;

    logic [7:0]        output_fault_debounce_cfg_ff;
    logic [15:0]       ext_temp_gain_cal_ff;
    logic [15:0]       ext_temp_offset_cal_ff;
    logic [55:0]       alert_fault_mask_bank_ff;
    logic [CNT_W:0]    viol_cnt_ff;
    logic [CNT_W:0]    nxt_viol_cnt;
    vff_state_e        state_ff;
    vff_state_e        nxt_state;
    logic              gain_ok;
    logic              ofs_ok;
    logic              known_cmd;
    logic [55:0]       eff_status;
    logic signed [63:0] temp_prod;

    // linear-11 to fixed point with FRAC fraction bits
    function automatic logic signed [47:0] lin11_fix(input logic [15:0] v);
        logic signed [4:0]  e;
        logic signed [47:0] m;
        logic signed [6:0]  sh;
        e  = v[15:11];
        m  = 48'(signed'(v[MANT_W-1:0]));
        sh = 7'(e) + 7'(FRAC);
        if (sh >= 0) lin11_fix = m <<< sh;
        else         lin11_fix = m >>> (-sh);
    endfunction

    assign gain_ok = (lin11_fix(cmd_in.wdata[15:0]) >= GAIN_MIN)
                  && (lin11_fix(cmd_in.wdata[15:0]) <= GAIN_MAX);
    assign ofs_ok  = (lin11_fix(cmd_in.wdata[15:0]) >= -OFS_LIM)
                  && (lin11_fix(cmd_in.wdata[15:0]) <= OFS_LIM);
    assign known_cmd = (cmd_in.cmd == CMD_DEBOUNCE) || (cmd_in.cmd == CMD_GAIN)
                    || (cmd_in.cmd == CMD_OFFSET) || (cmd_in.cmd == CMD_MASK);

    // register writes; out-of-range values leave the old setting in place
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            output_fault_debounce_cfg_ff <= RST_DEBOUNCE;
            ext_temp_gain_cal_ff         <= RST_GAIN;
            ext_temp_offset_cal_ff       <= RST_OFFSET;
            alert_fault_mask_bank_ff     <= RST_MASK;
        end else if (cmd_in.wr) begin
            case (cmd_in.cmd)
                CMD_DEBOUNCE: output_fault_debounce_cfg_ff <= cmd_in.wdata[7:0];
                CMD_GAIN: if (gain_ok) ext_temp_gain_cal_ff <= cmd_in.wdata[15:0];
                CMD_OFFSET: if (ofs_ok) ext_temp_offset_cal_ff <= cmd_in.wdata[15:0];
                CMD_MASK: alert_fault_mask_bank_ff <= cmd_in.wdata;
                default: ;
            endcase
        end
    end

    // response: ack for accepted access, nack for unknown or rejected
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            rsp_out <= '0;
        end else begin
            rsp_out.ack  <= 1'b0;
            rsp_out.nack <= 1'b0;
            if (cmd_in.wr || cmd_in.rd) begin
                if (!known_cmd) begin
                    rsp_out.nack <= 1'b1;
                end else if (cmd_in.wr && cmd_in.cmd == CMD_GAIN && !gain_ok) begin
                    rsp_out.nack <= 1'b1;
                end else if (cmd_in.wr && cmd_in.cmd == CMD_OFFSET && !ofs_ok) begin
                    rsp_out.nack <= 1'b1;
                end else begin
                    rsp_out.ack <= 1'b1;
                end
            end
            if (cmd_in.rd) begin
                case (cmd_in.cmd)
                    CMD_DEBOUNCE: rsp_out.rdata <= {48'h0, output_fault_debounce_cfg_ff};
                    CMD_GAIN:     rsp_out.rdata <= {40'h0, ext_temp_gain_cal_ff};
                    CMD_OFFSET:   rsp_out.rdata <= {40'h0, ext_temp_offset_cal_ff};
                    CMD_MASK:     rsp_out.rdata <= alert_fault_mask_bank_ff;
                    default:      rsp_out.rdata <= 56'h0;
                endcase
            end
        end
    end

    // violation filter; count saturates at N+1 so a long run stays faulted
    always_comb begin
        nxt_viol_cnt = viol_cnt_ff;
        nxt_state    = state_ff;
        if (vout_sample) begin
            if (vout_ov_viol || vout_uv_viol) begin
                if (viol_cnt_ff <= {1'b0, output_fault_debounce_cfg_ff[CNT_LSB +: CNT_W]})
                    nxt_viol_cnt = viol_cnt_ff + (CNT_W+1)'(1);
            end else begin
                nxt_viol_cnt = '0;
            end
        end
        case (state_ff)
            // n of zero declares on the first violation, skipping the count state
            VFF_IDLE: begin
                if (nxt_viol_cnt > {1'b0, output_fault_debounce_cfg_ff[CNT_LSB +: CNT_W]})
                    nxt_state = VFF_FAULT;
                else if (nxt_viol_cnt != '0)
                    nxt_state = VFF_COUNT;
            end
            VFF_COUNT: begin
                if (nxt_viol_cnt == '0)
                    nxt_state = VFF_IDLE;
                else if (nxt_viol_cnt
                         > {1'b0, output_fault_debounce_cfg_ff[CNT_LSB +: CNT_W]})
                    nxt_state = VFF_FAULT;
            end
            VFF_FAULT: if (nxt_viol_cnt == '0) nxt_state = VFF_IDLE;
            default:   nxt_state = VFF_IDLE;
        endcase
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            viol_cnt_ff <= '0;
            state_ff    <= VFF_IDLE;
        end else begin
            viol_cnt_ff <= nxt_viol_cnt;
            state_ff    <= nxt_state;
        end
    end

    assign vout_fault = (state_ff == VFF_FAULT);

    // calibrated temperature: raw * gain + offset, 8 fraction bits kept
    // product formed outside the flop so the reset branch holds constants only
    assign temp_prod = (64'(temp_raw) * 64'(lin11_fix(ext_temp_gain_cal_ff))) >>> FRAC;

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            temp_cal       <= '0;
            temp_out_valid <= 1'b0;
        end else begin
            temp_out_valid <= temp_valid;
            if (temp_valid) begin
                temp_cal <= 32'(temp_prod + 64'(lin11_fix(ext_temp_offset_cal_ff)));
            end
        end
    end

    // alert: unmasked active status bits; the unused byte never alerts
    genvar gb;
    generate
        for (gb = 0; gb < MASK_BYTES; gb++) begin : g_byte
            if (gb == UNUSED_BYTE) begin : g_unused
                assign eff_status[gb*8 +: 8] = 8'h00;
            end else begin : g_used
                assign eff_status[gb*8 +: 8] = fault_status[gb*8 +: 8]
                                             & ~alert_fault_mask_bank_ff[gb*8 +: 8];
            end
        end
    endgenerate

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) alert_output_pin <= 1'b0;
        else         alert_output_pin <= |eff_status;
    end

    a_mask_blocks_alert: assert property (@(posedge mclk) disable iff (sys_rst)
        ((fault_status & ~alert_fault_mask_bank_ff & ~56'h00ff0000000000) == '0)
        |=> !alert_output_pin)
        else $error("masked fault reached alert pin");
    a_alert_follows: assert property (@(posedge mclk) disable iff (sys_rst)
        (|(fault_status[7:0] & ~alert_fault_mask_bank_ff[7:0])) |=> alert_output_pin)
        else $error("unmasked vout fault did not alert");
    a_gain_reject: assert property (@(posedge mclk) disable iff (sys_rst)
        (cmd_in.wr && cmd_in.cmd == CMD_GAIN && !gain_ok)
        |=> $stable(ext_temp_gain_cal_ff))
        else $error("rejected gain was stored");
    a_offset_reject: assert property (@(posedge mclk) disable iff (sys_rst)
        (cmd_in.wr && cmd_in.cmd == CMD_OFFSET && !ofs_ok)
        |=> $stable(ext_temp_offset_cal_ff))
        else $error("rejected offset was stored");
    a_clear_on_ok: assert property (@(posedge mclk) disable iff (sys_rst)
        (vout_sample && !vout_ov_viol && !vout_uv_viol) |=> (viol_cnt_ff == '0) && !vout_fault)
        else $error("good sample did not clear filter");
    a_fault_count: assert property (@(posedge mclk) disable iff (sys_rst)
        $rose(vout_fault) |-> viol_cnt_ff
            == {1'b0, output_fault_debounce_cfg_ff[CNT_LSB +: CNT_W]} + (CNT_W+1)'(1))
        else $error("fault declared at wrong count");
    a_no_early_fault: assert property (@(posedge mclk) disable iff (sys_rst)
        (viol_cnt_ff <= {1'b0, output_fault_debounce_cfg_ff[CNT_LSB +: CNT_W]}) |-> !vout_fault)
        else $error("fault before N+1 violations");
    // filter steps: the violation that completes the run, then the declared fault
    sequence s_run_done;
        vout_sample && (vout_ov_viol || vout_uv_viol)
            && (viol_cnt_ff == {1'b0, output_fault_debounce_cfg_ff[CNT_LSB +: CNT_W]});
    endsequence
    sequence s_fault_up;
        vout_fault;
    endsequence
    a_fault_on_run: assert property (@(posedge mclk) disable iff (sys_rst)
        s_run_done |=> s_fault_up)
        else $error("full violation run did not declare fault");
    a_mask_reset: assert property (@(posedge mclk)
        $fell(sys_rst) |-> alert_fault_mask_bank_ff == RST_MASK)
        else $error("mask not clear after reset");
endmodule

// file: design/vff_pkg.sv
// package: command codes, reset values, limits and carriers for the fault filter bank
package vff_pkg;
    localparam logic [7:0]  CMD_DEBOUNCE   = 8'hd8;
    localparam logic [7:0]  CMD_GAIN       = 8'hd9;
    localparam logic [7:0]  CMD_OFFSET     = 8'hda;
    localparam logic [7:0]  CMD_MASK       = 8'hdb;
    localparam logic [7:0]  RST_DEBOUNCE   = 8'h00;
    localparam logic [15:0] RST_GAIN       = 16'hba00;
    localparam logic [15:0] RST_OFFSET     = 16'h0000;
    localparam logic [55:0] RST_MASK       = 56'h00000000000000;
    localparam int          CNT_LSB        = 0;
    localparam int          CNT_W          = 4;
    localparam int          MANT_W         = 11;
    localparam int          MASK_BYTES     = 7;
    localparam int          UNUSED_BYTE    = 5;
    // limits as fixed point with 8 fraction bits: 0.1 rounded up, 10, 100
    localparam int          FRAC           = 8;
    localparam logic signed [47:0] GAIN_MIN = 48'sh1a;
    localparam logic signed [47:0] GAIN_MAX = 48'sha00;
    localparam logic signed [47:0] OFS_LIM  = 48'sh6400;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  cmd;
        logic [55:0] wdata;
    } vff_cmd_s;

    typedef struct packed {
        logic        ack;
        logic        nack;
        logic [55:0] rdata;
    } vff_rsp_s;

    typedef enum logic [1:0] {
        VFF_IDLE   = 2'b00,
        VFF_COUNT  = 2'b01,
        VFF_FAULT  = 2'b11
    } vff_state_e;
endpackage

// file: test/vff_bank_tb.sv
// self-checking bench for the fault filter bank
`timescale 1ns/1ps
module vff_bank_tb;
    import vff_pkg::*;
    logic               mclk, sys_rst, vout_sample, vout_ov_viol, vout_uv_viol, vout_fault;
    logic               temp_valid, temp_out_valid, alert_output_pin;
    logic signed [15:0] temp_raw;
    logic signed [31:0] temp_cal;
    logic [55:0]        fault_status, m;
    vff_cmd_s           cmd;
    vff_rsp_s           rsp;
    int                 err_count, comparisons, i, r;
    integer             seed = 46098;
    localparam logic [6:0] viol_pat = 7'b1101110;
    vff_bank vff_bank_i (.mclk(mclk), .sys_rst(sys_rst), .cmd_in(cmd), .rsp_out(rsp),
        .vout_sample(vout_sample), .vout_ov_viol(vout_ov_viol), .vout_uv_viol(vout_uv_viol),
        .vout_fault(vout_fault), .temp_valid(temp_valid), .temp_raw(temp_raw),
        .temp_out_valid(temp_out_valid), .temp_cal(temp_cal), .fault_status(fault_status),
        .alert_output_pin(alert_output_pin));
    vff_host vff_host_i (.mclk(mclk), .cmd_out(cmd), .rsp_in(rsp));
    initial begin
        mclk = 0;
        forever #5 mclk = ~mclk;
    end
    task automatic check(input string nm, input logic [55:0] exp, input logic [55:0] got);
        comparisons++;
        if (got !== exp) begin
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
            err_count++;
        end
    endtask
    task automatic wr(input logic [7:0] c, input logic [55:0] d, input logic bad);
        vff_host_i.access(1'b1, c, d);
        check("write resp", bad ? 2'b01 : 2'b10, {vff_host_i.rsp.ack, vff_host_i.rsp.nack});
    endtask
    task automatic rd(input logic [7:0] c, input logic [55:0] exp);
        vff_host_i.access(1'b0, c, 56'h0);
        check("read ack", 1'b1, vff_host_i.rsp.ack);
        check("read data", exp, vff_host_i.rsp.rdata);
    endtask
    // masked classes and the unused byte never reach the pin
    function automatic logic alert_exp(input logic [55:0] s, input logic [55:0] k);
        return |(s & ~k & ~(56'hff << (8 * UNUSED_BYTE)));
    endfunction
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        #200000;
        err_count++;
        close_out();
    end
    initial begin
        {sys_rst, vout_sample, vout_ov_viol, vout_uv_viol, temp_valid} = 5'b10000;
        temp_raw = 0;
        fault_status = 0;
        repeat (10) @(posedge mclk);
        #1 sys_rst = 0;
        rd(CMD_DEBOUNCE, RST_DEBOUNCE);
        rd(CMD_GAIN, RST_GAIN);
        rd(CMD_OFFSET, RST_OFFSET);
        rd(CMD_MASK, RST_MASK);
        $display("test reset values done");
        wr(CMD_GAIN, 56'h0014, 1);
        wr(CMD_GAIN, 56'hb819, 1);
        rd(CMD_GAIN, RST_GAIN);
        wr(CMD_GAIN, 56'h0002, 0);
        wr(CMD_OFFSET, 56'h00c8, 1);
        wr(CMD_OFFSET, 56'h07ce, 0);
        rd(CMD_OFFSET, 56'h07ce);
        wr(8'h55, 56'h1, 1);
        $display("test calibration ranges done");
        for (i = 0; i < 6; i++) begin
            r = $random(seed);
            @(posedge mclk);
            #1 {temp_valid, temp_raw} = {1'b1, r[15:0]};
            @(posedge mclk);
            #1 temp_valid = 0;
            check("temp valid", 1'b1, temp_out_valid);
            check("temp cal", 32'(2 * int'(temp_raw) - 12800), temp_cal);
        end
        $display("test temperature path done");
        wr(CMD_DEBOUNCE, 56'hf2, 0);
        // run broken after two samples must start over
        for (i = 6; i >= 0; i--) begin
            @(posedge mclk);
            #1 {vout_sample, vout_ov_viol, vout_uv_viol} = {1'b1, viol_pat[i] & i[0],
                viol_pat[i] & !i[0]};
            @(posedge mclk);
            #1 vout_sample = 0;
            check("vout fault", 7'b0000010 >> i & 7'h1, vout_fault);
        end
        // n of zero: the very first violation declares the fault
        wr(CMD_DEBOUNCE, 56'h00, 0);
        @(posedge mclk);
        #1 {vout_sample, vout_ov_viol, vout_uv_viol} = 3'b110;
        @(posedge mclk);
        #1 vout_sample = 0;
        check("vout fault n0", 1'b1, vout_fault);
        @(posedge mclk);
        #1 {vout_sample, vout_ov_viol} = 2'b10;
        @(posedge mclk);
        #1 vout_sample = 0;
        check("vout fault clear", 1'b0, vout_fault);
        $display("test fault filter done");
        for (i = 0; i < 10; i++) begin
            m = (i == 1) ? {56{1'b1}} : (i < 3) ? 56'h0 : 56'({$random(seed), $random(seed)});
            wr(CMD_MASK, m, 0);
            rd(CMD_MASK, m);
            fault_status = (i == 0) ? 56'hff << (8 * UNUSED_BYTE)
                : (i == 2) ? 56'h01 << (8 * (MASK_BYTES - 1))
                : 56'({$random(seed), $random(seed)});
            repeat (2) @(posedge mclk);
            #1 check("alert pin", alert_exp(fault_status, m), alert_output_pin);
        end
        $display("test alert mask done");
        // reset in mid-run must clear a mask the host has set
        sys_rst = 1;
        repeat (2) @(posedge mclk);
        #1 sys_rst = 0;
        rd(CMD_MASK, RST_MASK);
        $display("test mid-run reset done");
        close_out();
    end
endmodule

// file: test/vff_host.sv
// host-side command model for the fault filter bank
`timescale 1ns/1ps
module vff_host (
    // clock
    input  wire logic              mclk,
    // command and response
    output vff_pkg::vff_cmd_s      cmd_out,
    input  wire vff_pkg::vff_rsp_s rsp_in
);
    import vff_pkg::*;
    vff_rsp_s rsp;
    initial cmd_out = '0;
    // one access: command held for one cycle, then the registered response is sampled
    task automatic access(input logic w, input logic [7:0] c, input logic [55:0] d);
        @(posedge mclk);
        #1 cmd_out = '{wr: w, rd: !w, cmd: c, wdata: d};
        @(posedge mclk);
        // released data inverted so a stale value is never mistaken for live
        #1 cmd_out = '{wr: 1'b0, rd: 1'b0, cmd: ~c, wdata: ~d};
        rsp = rsp_in;
    endtask
endmodule
